// file: smcg_pkg.sv
package smcg_pkg;

    // Sleep mode choice codes (three-bit field).
    localparam logic [2:0] MODE_IDLE    = 3'h0;
    localparam logic [2:0] MODE_NOISE   = 3'h1;
    localparam logic [2:0] MODE_PDOWN   = 3'h2;
    localparam logic [2:0] MODE_STANDBY = 3'h4;

    // Field positions inside the sleep control register image.
    localparam int SE_POS      = 0;
    localparam int SM_LSB      = 1;
    // Field positions inside the peripheral clock stop register image.
    localparam int TIMER_POS   = 0;
    localparam int CONV_POS    = 1;
    localparam int SERIAL_POS  = 2;
    // Reset values.
    localparam logic [3:0] SLEEP_CTRL_RESET = 4'h0;
    localparam logic [2:0] CLK_STOP_RESET   = 3'h0;

    // Wake-up hold of the core, in main clock cycles.
    localparam int WAKE_HOLD_CYCLES = 4;
    // Oscillator start-up after power-down, in main clock cycles.
    localparam int OSC_START_CYCLES = 6;
    localparam logic [3:0] WAKE_HOLD_CNT = 4'(WAKE_HOLD_CYCLES);
    localparam logic [3:0] OSC_START_CNT = 4'(OSC_START_CYCLES);
    localparam int PIN_COUNT = 8;

    // Sleep sequencer states.
    typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_OSC, ST_HOLD} smcg_state_t;

    // Clock domain enables toward the clock tree.
    typedef struct packed {
        logic cpu;
        logic flash;
        logic periph;
        logic conv;
        logic osc;
    } smcg_clk_t;

    // Gated per-peripheral clock enables.
    typedef struct packed {
        logic serial;
        logic conv;
        logic timer;
    } smcg_pclk_t;

    // Wake-up sources.
    typedef struct packed {
        logic watchdog;
        logic extLevel;
        logic extEdge;
        logic pinChange;
        logic convDone;
        logic otherIo;
        logic supplyMon;
    } smcg_wake_t;

endpackage

// file: smcg_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for asynchronous wake sources.
module smcg_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         mclk,
    input  wire logic         rstn,
    // Data.
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] stage1; // First stage, read only by the second.

    // The first stage may go metastable; only the second stage is used.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule

// file: smcg_sleep_ctrl.sv
`timescale 1ns/1ps
// Contract
// [R01] Idle stops cpu and flash clocks only.
// [R02] Noise reduction also stops peripheral clock.
// [R03] Power-down stops all clocks and oscillator.
// [R04] Standby equals power-down, oscillator kept.
// [R05] Sleep only if enable set at halt.
// [R06] Hold core four cycles plus start-up.
// [R07] Register file and memory preserved.
// [R08] Reset during sleep restarts at vector.
// [R09] Deep modes wake on watchdog, level, pinchange.
// [R10] Non-idle modes ignore edge external interrupt.
// [R11] Idle/noise entry starts conversion if enabled.
// [R12] Stopped peripheral frozen, access blocked.
// [R13] Clearing stop bit resumes peripheral state.
// [R14] Stop bits act in active and idle.
// [R15] Power-down disables comparator automatically.
// [R16] Peripheral-clock-off modes disable input buffers; the code keeps the buffers of wakePinMask pins enabled.
// [R17] Watchdog and converter stay enabled in sleep.
// [R18] Converter re-enable forces extended conversion.
// [R19] Reference on when comparator or converter need.
// [R20] Input buffer off register disables buffers.
// [R21] Codes 011,101,110,111 are reserved.
// [R22] Power-down wake counts six-cycle start-up.
// [R23] Stop register: serial, converter, timer bits.
// [R24] Reserved mode at halt does not sleep.
module smcg_sleep_ctrl (
    // Clock and reset.
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    // Core side.
    input  wire logic                      haltExec,
    input  wire logic                      intEnabled,
    output logic                           coreHold,
    output logic                           wakeIrq,
    // Software register images.
    input  wire logic [3:0]                sleep_control_reg,
    input  wire logic [2:0]                peripheral_clock_stop_reg,
    input  wire logic                      comparator_off_bit,
    input  wire logic                      convEnable,
    input  wire logic                      watchdogEnable,
    input  wire logic                      cmpUsesRef,
    input  wire logic [7:0]                input_buffer_off_reg,
    input  wire logic [7:0]                wakePinMask,
    // Peripheral access requests.
    input  wire logic [2:0]                periphAccessReq,
    output logic      [2:0]                periphAccessOk,
    // Wake sources from outside the clock domain.
    input  smcg_pkg::smcg_wake_t           wakeIn,
    // Clock tree and analog controls.
    output smcg_pkg::smcg_clk_t            clkEn,
    output smcg_pkg::smcg_pclk_t           pclkEn,
    output logic                           convStart,
    output logic                           convExtended,
    output logic                           convPowered,
    output logic                           comparatorOn,
    output logic                           refOn,
    output logic                           watchdogOn,
    output logic [smcg_pkg::PIN_COUNT-1:0] inputBufEn,
    output logic [2:0]                     sleepModeNow
);

    // All state of the block.
    typedef struct packed {
        smcg_pkg::smcg_state_t           st;
        logic [2:0]                      mode;
        logic [3:0]                      cnt;
        logic                            convWasOn;
        logic                            extNext;
        smcg_pkg::smcg_clk_t             clk;
        smcg_pkg::smcg_pclk_t            pclk;
        logic [2:0]                      access;
        logic                            hold;
        logic                            irq;
        logic                            cstart;
        logic                            cext;
        logic                            cpow;
        logic                            cmp;
        logic                            refPow;
        logic                            wdog;
        logic [smcg_pkg::PIN_COUNT-1:0]  bufOn;
    } smcg_state_all_t;

    smcg_state_all_t state;      // Registered state.
    smcg_state_all_t next_state; // Next value.
    smcg_pkg::smcg_wake_t wakeSync; // Synchronised wake sources.

    logic       se;        // Sleep enable bit.
    logic [2:0] smode;     // Sleep mode choice.
    logic       modeValid; // Mode is one of the four defined codes.
    logic       wakeNow;   // Wake condition for the current mode.
    logic       deep;      // Non-idle mode, from sleep entry until back in run.

    assign se    = sleep_control_reg[smcg_pkg::SE_POS];
    assign smode = sleep_control_reg[smcg_pkg::SM_LSB +: 3];

    // Asynchronous wake sources pass a two-flop synchroniser first.
    smcg_sync #(.W($bits(smcg_pkg::smcg_wake_t))) uSync (
        .mclk (mclk),
        .rstn (rstn),
        .din  (wakeIn),
        .dout (wakeSync)
    );

    // Mode decode and wake qualification.
    always_comb begin
        modeValid = (smode == smcg_pkg::MODE_IDLE) || (smode == smcg_pkg::MODE_NOISE) ||
                    (smode == smcg_pkg::MODE_PDOWN) || (smode == smcg_pkg::MODE_STANDBY); // [R21]
        deep = (state.st != smcg_pkg::ST_RUN) && (state.mode != smcg_pkg::MODE_IDLE);
        wakeNow = 1'b0;
        if (state.mode == smcg_pkg::MODE_IDLE) begin
            // Idle wakes on any enabled source, edges included.
            wakeNow = wakeSync.watchdog | wakeSync.extLevel | wakeSync.extEdge |
                      wakeSync.pinChange | wakeSync.convDone | wakeSync.otherIo |
                      wakeSync.supplyMon;
        end else if (state.mode == smcg_pkg::MODE_NOISE) begin
            // Edge mode on the external line is ignored here.
            wakeNow = wakeSync.watchdog | wakeSync.extLevel | wakeSync.pinChange |
                      wakeSync.convDone | wakeSync.supplyMon; // [R10]
        end else begin
            // Power-down and standby: only watchdog, level and pin change.
            wakeNow = wakeSync.watchdog | wakeSync.extLevel | wakeSync.pinChange; // [R09] [R10]
        end
        wakeNow = wakeNow & intEnabled;
    end

    // Next-state logic for the sequencer and all outputs.
    always_comb begin
        next_state        = state;
        next_state.cstart = 1'b0;
        next_state.irq    = 1'b0;
        case (state.st)
            smcg_pkg::ST_RUN: begin
                next_state.hold = 1'b0;
                // Enter only with enable set and a valid mode.
                if (haltExec && se && modeValid) begin // [R05] [R24]
                    next_state.st   = smcg_pkg::ST_SLEEP;
                    next_state.mode = smode;
                    next_state.hold = 1'b1;
                    // Conversion starts on idle or noise-reduction entry.
                    if (convEnable && ((smode == smcg_pkg::MODE_IDLE) ||
                                       (smode == smcg_pkg::MODE_NOISE))) begin
                        next_state.cstart = 1'b1; // [R11]
                    end
                end
            end
            smcg_pkg::ST_SLEEP: begin
                if (wakeNow) begin
                    if (state.mode == smcg_pkg::MODE_PDOWN) begin
                        next_state.st  = smcg_pkg::ST_OSC;
                        next_state.cnt = smcg_pkg::OSC_START_CNT; // [R22]
                    end else begin
                        next_state.st  = smcg_pkg::ST_HOLD;
                        next_state.cnt = smcg_pkg::WAKE_HOLD_CNT; // [R06]
                    end
                end
            end
            smcg_pkg::ST_OSC: begin
                // Oscillator runs again; count its start-up.
                if (state.cnt == 4'h1) begin
                    next_state.st  = smcg_pkg::ST_HOLD;
                    next_state.cnt = smcg_pkg::WAKE_HOLD_CNT; // [R06]
                end else begin
                    next_state.cnt = state.cnt - 4'h1; // [R22]
                end
            end
            smcg_pkg::ST_HOLD: begin
                // Core held four cycles, then interrupt handler runs.
                if (state.cnt == 4'h1) begin
                    next_state.st   = smcg_pkg::ST_RUN;
                    next_state.hold = 1'b0;
                    next_state.irq  = 1'b1; // [R06]
                end else begin
                    next_state.cnt = state.cnt - 4'h1;
                end
            end
            default: begin
                next_state.st = smcg_pkg::ST_RUN;
            end
        endcase

        // Clock domain enables follow the mode while asleep.
        next_state.clk = '{cpu: 1'b1, flash: 1'b1, periph: 1'b1, conv: 1'b1, osc: 1'b1};
        if (next_state.st == smcg_pkg::ST_SLEEP) begin
            next_state.clk.cpu   = 1'b0; // [R01]
            next_state.clk.flash = 1'b0; // [R01]
            if (next_state.mode == smcg_pkg::MODE_NOISE) begin
                next_state.clk.periph = 1'b0; // [R02]
            end else if (next_state.mode == smcg_pkg::MODE_PDOWN) begin
                next_state.clk.periph = 1'b0; // [R03]
                next_state.clk.conv   = 1'b0;
                next_state.clk.osc    = 1'b0;
            end else if (next_state.mode == smcg_pkg::MODE_STANDBY) begin
                next_state.clk.periph = 1'b0; // [R04]
                next_state.clk.conv   = 1'b0;
            end
        end else if (next_state.st != smcg_pkg::ST_RUN) begin
            // Waking: oscillator back, core clocks still off until release.
            next_state.clk.cpu   = 1'b0;
            next_state.clk.flash = 1'b0;
        end

        // Per-peripheral clocks: stop bits gate on top of the domain clocks.
        next_state.pclk.timer  = next_state.clk.periph &
                                 ~peripheral_clock_stop_reg[smcg_pkg::TIMER_POS]; // [R14] [R23]
        next_state.pclk.serial = next_state.clk.periph &
                                 ~peripheral_clock_stop_reg[smcg_pkg::SERIAL_POS]; // [R14] [R23]
        next_state.pclk.conv   = next_state.clk.conv &
                                 ~peripheral_clock_stop_reg[smcg_pkg::CONV_POS]; // [R23]
        // Access to a stopped peripheral is refused; its state is only
        // frozen, never cleared, so clearing the bit resumes it.
        next_state.access = periphAccessReq & ~peripheral_clock_stop_reg; // [R12] [R13]

        // Converter power is kept in every mode while enabled and its stop bit is clear.
        next_state.cpow = convEnable & ~peripheral_clock_stop_reg[smcg_pkg::CONV_POS]; // [R17]
        next_state.wdog = watchdogEnable; // [R17]
        // After the converter is switched back on, mark next run extended.
        next_state.convWasOn = next_state.cpow;
        if (next_state.cpow && !state.convWasOn) begin
            next_state.cext = 1'b1; // [R18]
        end else if (state.cstart || convStart) begin
            next_state.cext = 1'b0;
        end

        // Comparator is forced off in power-down.
        next_state.cmp = ~comparator_off_bit &
                         ~((next_state.st == smcg_pkg::ST_SLEEP) &&
                           (next_state.mode == smcg_pkg::MODE_PDOWN)); // [R15]
        // Reference follows its users regardless of mode.
        next_state.refPow = (next_state.cmp & cmpUsesRef) | next_state.cpow; // [R19]

        // Input buffers: software disable always; non-idle sleep disable unless wake pin.
        next_state.bufOn = ~input_buffer_off_reg; // [R20]
        if ((next_state.st == smcg_pkg::ST_SLEEP) &&
            (next_state.mode != smcg_pkg::MODE_IDLE)) begin
            next_state.bufOn = next_state.bufOn & wakePinMask; // [R16]
        end
    end

    // State register. Reset returns to run; the core restarts from its
    // vector on the same reset, and no memory contents are touched here.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state        <= '0;
            state.st     <= smcg_pkg::ST_RUN; // [R08]
            state.clk    <= '1;
            state.pclk   <= '1;
            state.cmp    <= 1'b1;
            state.bufOn  <= '1;
        end else begin
            state <= next_state;
        end
    end

    // The block never drives data stores, so register file and memory
    // keep their contents across sleep. [R07]
    assign coreHold       = state.hold;
    assign wakeIrq        = state.irq;
    assign periphAccessOk = state.access;
    assign clkEn          = state.clk;
    assign pclkEn         = state.pclk;
    assign convStart      = state.cstart;
    assign convExtended   = state.cext;
    assign convPowered    = state.cpow;
    assign comparatorOn   = state.cmp;
    assign refOn          = state.refPow;
    assign watchdogOn     = state.wdog;
    assign inputBufEn     = state.bufOn;
    assign sleepModeNow   = deep ? state.mode : state.mode;

endmodule

// file: smcg_wake_src.sv
`timescale 1ns/1ps
// Far side wake sources, which change away from the clock edge as real events do.
module smcg_wake_src (
    // Clock used only to time how long a source stays raised.
    input  wire logic            mclk,
    // Wake lines toward the block.
    output smcg_pkg::smcg_wake_t wakeIn
);
    // Raise the chosen sources for n cycles, then drop them back to quiet low.
    // A level source is held long enough to pass the two-flop synchroniser.
    task automatic raise(input logic [6:0] k, input int n);
        #3 wakeIn = k;
        repeat (n) @(posedge mclk);
        #3 wakeIn = '0;
    endtask

    // All sources are quiet at start.
    initial wakeIn = '0;
endmodule

// file: smcg_sleep_ctrl_sva.sv
`timescale 1ns/1ps
// Port-level checks of the sleep sequencer.
module smcg_sleep_ctrl_sva (
    // Clock and reset.
    input wire logic                mclk,
    input wire logic                rstn,
    // Core side.
    input wire logic                haltExec,
    input wire logic                coreHold,
    input wire logic                wakeIrq,
    // Controls.
    input wire logic [3:0]          sleep_control_reg,
    input wire logic [2:0]          peripheral_clock_stop_reg,
    input wire logic [2:0]          periphAccessReq,
    input wire logic                watchdogEnable,
    // Watched outputs.
    input wire logic [2:0]          periphAccessOk,
    input wire smcg_pkg::smcg_clk_t clkEn,
    input wire logic                comparatorOn,
    input wire logic                watchdogOn
);
    // One clock domain, so clocking and reset are given once.
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    // A halt that is taken from run with the given mode code.
    sequence halt_in(logic [2:0] m);
        haltExec && sleep_control_reg[0] && !coreHold && sleep_control_reg[3:1] == m;
    endsequence

    // After a taken halt the core is held and the clock domains match the mode.
    property enter(logic [2:0] m, logic [4:0] c);
        halt_in(m) |=> coreHold && clkEn == c;
    endproperty

    idle_clocks_a:
        assert property (enter(smcg_pkg::MODE_IDLE, 5'h07)) else $error("idle clocks wrong");
    noise_clocks_a:
        assert property (enter(smcg_pkg::MODE_NOISE, 5'h03)) else $error("noise clocks wrong");
    pdown_clocks_a:
        assert property (enter(smcg_pkg::MODE_PDOWN, 5'h00)) else $error("pdown clocks wrong");
    standby_clocks_a:
        assert property (enter(smcg_pkg::MODE_STANDBY, 5'h01)) else $error("standby clocks wrong");
    no_sleep_a:
        assert property (haltExec && !coreHold && (!sleep_control_reg[0] ||
            sleep_control_reg[3:1] inside {3'h3, 3'h5, 3'h6, 3'h7}) |=> !coreHold)
            else $error("sleep entered without valid request");
    wake_pulse_a:
        assert property (wakeIrq |-> $past(coreHold) && !coreHold ##1 !wakeIrq)
            else $error("wake pulse malformed");
    osc_wait_a:
        assert property (coreHold && $rose(clkEn.osc) |-> coreHold [*8])
            else $error("core released before oscillator start-up");
    access_gate_a:
        assert property ($past(rstn) |->
            periphAccessOk == ($past(periphAccessReq) & ~$past(peripheral_clock_stop_reg)))
            else $error("stopped peripheral access not blocked");
    cmp_off_a:
        assert property (coreHold && !clkEn.osc |-> !comparatorOn)
            else $error("comparator on in power-down");
    dog_on_a:
        assert property ($past(rstn) |-> watchdogOn == $past(watchdogEnable))
            else $error("watchdog enable not kept");
endmodule

bind smcg_sleep_ctrl smcg_sleep_ctrl_sva i_smcg_sleep_ctrl_sva (
    .mclk(mclk), .rstn(rstn), .haltExec(haltExec), .coreHold(coreHold), .wakeIrq(wakeIrq),
    .sleep_control_reg(sleep_control_reg), .peripheral_clock_stop_reg(peripheral_clock_stop_reg),
    .periphAccessReq(periphAccessReq), .watchdogEnable(watchdogEnable),
    .periphAccessOk(periphAccessOk), .clkEn(clkEn), .comparatorOn(comparatorOn),
    .watchdogOn(watchdogOn)
);

// file: test_smcg_sleep_ctrl.sv
`timescale 1ns/1ps
// Self-checking bench for the sleep and clock gating controller.
module test_smcg_sleep_ctrl;
    // Clock, reset and counters.
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    int   nMismatch = 0;
    int   cmpCount = 0;
    int   lat[4];
    int   n;
    // Design inputs and outputs.
    logic                 haltExec, intEnabled, comparator_off_bit, convEnable;
    logic                 watchdogEnable, cmpUsesRef, coreHold, wakeIrq, convStart;
    logic                 convExtended, convPowered, comparatorOn, refOn, watchdogOn;
    logic [3:0]           sleep_control_reg;
    logic [2:0]           peripheral_clock_stop_reg, periphAccessReq, periphAccessOk;
    logic [2:0]           sleepModeNow;
    logic [7:0]           input_buffer_off_reg, wakePinMask, inputBufEn;
    smcg_pkg::smcg_wake_t wakeIn;
    smcg_pkg::smcg_clk_t  clkEn;
    smcg_pkg::smcg_pclk_t pclkEn;
    // Per-mode tables: mode code, clock enables, waking source.
    logic [2:0] md[4] = '{smcg_pkg::MODE_IDLE, smcg_pkg::MODE_NOISE,
                          smcg_pkg::MODE_STANDBY, smcg_pkg::MODE_PDOWN};
    logic [4:0] ce[4] = '{5'h07, 5'h03, 5'h01, 5'h00};
    logic [6:0] wk[4] = '{7'h10, 7'h04, 7'h20, 7'h08};
    logic [3:0] bad[5] = '{4'h4, 4'h7, 4'hb, 4'hd, 4'hf};

    // Clock of 25 ns period.
    always #12.5 mclk = ~mclk;

    smcg_sleep_ctrl i_smcg_sleep_ctrl (.mclk(mclk), .rstn(rstn), .haltExec(haltExec),
        .intEnabled(intEnabled), .coreHold(coreHold), .wakeIrq(wakeIrq),
        .sleep_control_reg(sleep_control_reg),
        .peripheral_clock_stop_reg(peripheral_clock_stop_reg),
        .comparator_off_bit(comparator_off_bit), .convEnable(convEnable),
        .watchdogEnable(watchdogEnable), .cmpUsesRef(cmpUsesRef),
        .input_buffer_off_reg(input_buffer_off_reg), .wakePinMask(wakePinMask),
        .periphAccessReq(periphAccessReq), .periphAccessOk(periphAccessOk), .wakeIn(wakeIn),
        .clkEn(clkEn), .pclkEn(pclkEn), .convStart(convStart), .convExtended(convExtended),
        .convPowered(convPowered), .comparatorOn(comparatorOn), .refOn(refOn),
        .watchdogOn(watchdogOn), .inputBufEn(inputBufEn), .sleepModeNow(sleepModeNow));

    smcg_wake_src i_smcg_wake_src (.mclk(mclk), .wakeIn(wakeIn));

    // Compare one value; case inequality so an unknown never passes.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic endSim();
        $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
        if (nMismatch == 0 && cmpCount > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Issue one halt with the given control image; waits out any raised source first.
    task automatic halt_at(input logic [3:0] ctrl);
        wait fork;
        @(posedge mclk);
        sleep_control_reg <= ctrl;
        haltExec <= 1'b1;
        @(posedge mclk);
        haltExec <= 1'b0;
        #1;
    endtask

    // Raise a source and count cycles to release; a lost wake ends the run when must is set.
    task automatic wake(input logic [6:0] k, input int lim, input bit must, output int c);
        c = 0;
        fork
            i_smcg_wake_src.raise(k, 14);
        join_none
        while (wakeIrq !== 1'b1 && c < lim) begin
            @(posedge mclk);
            #1 c++;
        end
        if (must && c >= lim) begin
            nMismatch++;
            endSim();
        end
    endtask

    // Main sequence.
    initial begin
        {haltExec, comparator_off_bit, convEnable, cmpUsesRef} = 4'h0;
        {intEnabled, watchdogEnable} = 2'h3;
        sleep_control_reg = 4'h0;
        peripheral_clock_stop_reg = 3'h0;
        periphAccessReq = 3'h7;
        input_buffer_off_reg = 8'h00;
        wakePinMask = 8'h05;
        repeat (5) @(posedge mclk);
        #1 chk(clkEn, 5'h1f);
        @(posedge mclk) rstn <= 1'b1;
        // Static controls: reference, buffers, stop bits, converter power.
        @(posedge mclk) {cmpUsesRef, input_buffer_off_reg, peripheral_clock_stop_reg} <= 12'h985;
        // Nothing needs the reference yet, so it must be off after release.
        #1 chk(refOn, 1'b0);
        @(posedge mclk) #1 chk(refOn, 1'b1);
        chk(inputBufEn, 8'hcf);
        chk(pclkEn, 3'h2);
        chk(periphAccessOk, 3'h2);
        @(posedge mclk) {cmpUsesRef, input_buffer_off_reg, convEnable} <= 10'h001;
        @(posedge mclk) #1 chk(refOn, 1'b1);
        chk(convExtended, 1'b1);
        // Refused halts: sleep disabled or a reserved mode code.
        foreach (bad[j]) begin
            halt_at(bad[j]);
            chk({coreHold, clkEn}, 6'h1f);
        end
        // Each mode: entry clocks, ignored sources outside idle, then a valid wake.
        foreach (md[i]) begin
            halt_at({md[i], 1'b1});
            chk(clkEn, ce[i]);
            chk({coreHold, convStart}, {1'b1, i < 2});
            chk(pclkEn, (i < 2) ? 3'h2 : 3'h0);
            chk(inputBufEn, (i == 0) ? 8'hff : 8'h05);
            chk(comparatorOn, i != 3);
            chk({watchdogOn, convPowered, sleepModeNow}, {2'h3, md[i]});
            if (i > 0) begin
                wake(7'h12, 20, 1'b0, n);
                chk(n, 20);
            end
            wake(wk[i], 60, 1'b1, lat[i]);
            chk({coreHold, clkEn}, 6'h1f);
            @(posedge mclk) #1 chk(wakeIrq, 1'b0);
        end
        chk(lat[3] - lat[2], 6);
        chk(lat[2], lat[0]);
        chk(convExtended, 1'b0);
        // Clearing the stop bits resumes clocks and access.
        @(posedge mclk) peripheral_clock_stop_reg <= 3'h0;
        @(posedge mclk) #1 chk({pclkEn, periphAccessOk}, 6'h3f);
        // Reset in mid-sleep returns to run with all clocks.
        halt_at(4'h5);
        @(posedge mclk) rstn <= 1'b0;
        @(posedge mclk) #1 chk({coreHold, clkEn}, 6'h1f);
        // Release again: the block comes back in run, converter power rises anew.
        @(posedge mclk) rstn <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk({coreHold, clkEn, refOn}, 7'h3f);
        chk(convExtended, 1'b1);
        endSim();
    end
endmodule
